//--- logic/solenoid_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SOLENOID_MAP_SVH
`define SOLENOID_MAP_SVH

`define CLK_HZ 125000000
`define CTRL_OFS 32'h0000_0000
`define KEEP_OFS 32'h0000_0004
`define PERIOD_OFS 32'h0000_0008
`define PEAK_OFS 32'h0000_000C
`define HOLD_OFS 32'h0000_0010
`define STAT_OFS 32'h0000_0014
`define CTRL_ENABLE_BIT 0
`define CTRL_EXT_FREQ_BIT 1
`define CTRL_EXT_PEAK_BIT 2
`define CTRL_EXT_HOLD_BIT 3
`define CTRL_RESET 32'h0000_0000
// default pwm rate 20 kHz: period in cycles
`define PWM_DEF_HZ 20000
`define PWM_DEF_CYC (`CLK_HZ / `PWM_DEF_HZ)
// external rate limits 25 kHz .. 20 kHz
`define PWM_MAX_HZ 25000
`define PWM_MIN_CYC (`CLK_HZ / `PWM_MAX_HZ)
// minimum duty 7.5 percent, in tenths of percent
`define DMIN_PERMILLE 75
// references in millivolts
`define PEAK_DEF_MV 300
`define HOLD_DEF_MV 50
`define PEAK_MAX_MV 900
`define HOLD_MAX_MV 150
// keep time default 100 ms
`define KEEP_DEF_MS 100
`define KEEP_DEF_CYC ((`CLK_HZ / 1000) * `KEEP_DEF_MS)
`define START_DELAY_US 50

`endif

//--- logic/solenoid_peak_hold_pwm.sv
// peak and hold pwm solenoid controller with ahb-lite registers
`timescale 1ns/10ps
`include "solenoid_map.svh"

// Notes on behaviour
// RULE_01 - enable high starts activation; pullup default
// RULE_02 - three states: off, peak, hold
// RULE_03 - keep expiry swaps peak for hold reference
// RULE_04 - hold regulates while enable stays high
// RULE_05 - enable low stops switching, gate low
// RULE_06 - gate high until sense exceeds reference
// RULE_07 - gate stays low until next pwm tick
// RULE_08 - gate forced high for minimum duty
// RULE_09 - zero setting gives default pwm rate
// RULE_10 - external rate between 25 and 20 kHz
// RULE_11 - zero peak setting uses internal default
// RULE_12 - low settings clamp to 300/50 mV
// RULE_13 - peak reference up to 900 mV
// RULE_14 - hold reference 50 to 150 mV
// RULE_15 - small variant fixes hold at 50 mV
// RULE_16 - hold settings independent, sixth of peak
// RULE_17 - status pulldown released on fault
// RULE_18 - supply low lockout input is a fault
// RULE_19 - thermal fault with hysteresis
// RULE_20 - minimum on time 7.5 percent period
// RULE_21 - switching starts within 50 us
// RULE_22 - fault forces off, restart in peak
// RULE_23 - keep counter loaded on enable rise
module solenoid_peak_hold_pwm
   #(parameter logic HOLD_SETTABLE = 1'b1,
     parameter logic [31:0] KEEP_CYCLES = `KEEP_DEF_CYC)
   (input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic enable_pin,
    input wire logic [9:0] sense_mv,
    input wire solenoid_pkg::protect_in_t protect_in,
    output solenoid_pkg::switch_out_t switch_out);
   import solenoid_pkg::*;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [19:0] dmin_of(input logic [19:0] per);
      logic [31:0] p;
      p = ({12'h000, per} * 32'(`DMIN_PERMILLE) + 32'd999) / 32'd1000;
      dmin_of = (p[19:0] == 20'h00000) ? 20'h00001 : p[19:0];
   endfunction : dmin_of

   function automatic logic [9:0] clamp_mv(input logic [9:0] v,
                                           input logic [9:0] dflt,
                                           input logic [9:0] vmax);
      if (v < dflt)
         clamp_mv = dflt;
      else if (v > vmax)
         clamp_mv = vmax;
      else
         clamp_mv = v;
   endfunction : clamp_mv

   // keeps a written period inside the settable rate range
   function automatic logic [19:0] clamp_per(input logic [19:0] v);
      if (v < 20'(`PWM_MIN_CYC))
         clamp_per = 20'(`PWM_MIN_CYC);
      else if (v > 20'(`PWM_DEF_CYC))
         clamp_per = 20'(`PWM_DEF_CYC);
      else
         clamp_per = v;
   endfunction : clamp_per

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [1:0] en_sync_r;
   logic [1:0] uv_sync_r;
   logic [1:0] ot_sync_r;
   logic [1:0] ut_sync_r;
   logic [9:0] sense_s1_r;
   logic [9:0] sense_s2_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_sync_r <= 2'b11;
         uv_sync_r <= 2'b00;
         ot_sync_r <= 2'b00;
         ut_sync_r <= 2'b00;
         sense_s1_r <= 10'h000;
         sense_s2_r <= 10'h000;
      end else begin
         en_sync_r <= {en_sync_r[0], enable_pin};
         uv_sync_r <= {uv_sync_r[0], protect_in.supply_low_lockout};
         ot_sync_r <= {ot_sync_r[0], protect_in.overtemp};
         ut_sync_r <= {ut_sync_r[0], protect_in.undertemp};
         sense_s1_r <= sense_mv;
         sense_s2_r <= sense_s1_r;
      end
   end

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   logic [31:0] ctrl_r;
   logic [31:0] keep_r;
   logic [19:0] period_r;
   logic [9:0] peak_set_r;
   logic [9:0] hold_set_r;
   logic dph_wr_r;
   logic [31:0] dph_addr_r;
   logic thermal_r;
   phase_t phase_r;
   logic gate_r;

   wire logic addr_ph = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_r <= 1'b0;
         dph_addr_r <= 32'h0000_0000;
      end else if (hready) begin
         dph_wr_r <= addr_ph & hwrite;
         dph_addr_r <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `CTRL_RESET;
         keep_r <= KEEP_CYCLES;
         period_r <= 20'(`PWM_DEF_CYC);
         peak_set_r <= 10'(`PEAK_DEF_MV);
         hold_set_r <= 10'(`HOLD_DEF_MV);
      end else if (dph_wr_r) begin
         if (dph_addr_r[7:0] == `CTRL_OFS)
            ctrl_r <= {28'h0000000, hwdata[3:0]};
         else if (dph_addr_r[7:0] == `KEEP_OFS)
            keep_r <= hwdata;
         else if (dph_addr_r[7:0] == `PERIOD_OFS)
            period_r <= clamp_per(hwdata[19:0]);              // [RULE_10]
         else if (dph_addr_r[7:0] == `PEAK_OFS)
            peak_set_r <= clamp_mv(hwdata[9:0], 10'(`PEAK_DEF_MV),
                                   10'(`PEAK_MAX_MV));        // [RULE_12]
         else if (dph_addr_r[7:0] == `HOLD_OFS)
            hold_set_r <= clamp_mv(hwdata[9:0], 10'(`HOLD_DEF_MV),
                                   10'(`HOLD_MAX_MV));        // [RULE_12]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ph && !hwrite) begin
         if (haddr[7:0] == `CTRL_OFS)
            hrdata <= ctrl_r;
         else if (haddr[7:0] == `KEEP_OFS)
            hrdata <= keep_r;
         else if (haddr[7:0] == `PERIOD_OFS)
            hrdata <= {12'h000, period_r};
         else if (haddr[7:0] == `PEAK_OFS)
            hrdata <= {22'h0, peak_set_r};
         else if (haddr[7:0] == `HOLD_OFS)
            hrdata <= {22'h0, hold_set_r};
         else if (haddr[7:0] == `STAT_OFS)
            hrdata <= {26'h0, gate_r, thermal_r, uv_sync_r[1],
                       en_sync_r[1], phase_r};
         else
            hrdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ---------------------------------------------
   // effective settings
   // ---------------------------------------------
   logic [19:0] per_eff;
   logic [9:0] peak_ref;
   logic [9:0] hold_ref;
   logic [9:0] vref;

   always_comb begin
      if (!ctrl_r[`CTRL_EXT_FREQ_BIT])                    // [RULE_09]
         per_eff = 20'(`PWM_DEF_CYC);
      else if (period_r < 20'(`PWM_MIN_CYC))              // [RULE_10]
         per_eff = 20'(`PWM_MIN_CYC);
      else if (period_r > 20'(`PWM_DEF_CYC))
         per_eff = 20'(`PWM_DEF_CYC);
      else
         per_eff = period_r;
      if (!ctrl_r[`CTRL_EXT_PEAK_BIT])                    // [RULE_11]
         peak_ref = 10'(`PEAK_DEF_MV);
      else                                                // [RULE_12] [RULE_13]
         peak_ref = clamp_mv(peak_set_r, 10'(`PEAK_DEF_MV),
                             10'(`PEAK_MAX_MV));
      if (!HOLD_SETTABLE || !ctrl_r[`CTRL_EXT_HOLD_BIT])  // [RULE_15]
         hold_ref = 10'(`HOLD_DEF_MV);
      else                                                // [RULE_14] [RULE_16]
         hold_ref = clamp_mv(hold_set_r, 10'(`HOLD_DEF_MV),
                             10'(`HOLD_MAX_MV));
   end

   // ---------------------------------------------
   // protection
   // ---------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         thermal_r <= 1'b0;
      else if (ot_sync_r[1])                              // [RULE_19]
         thermal_r <= 1'b1;
      else if (ut_sync_r[1])
         thermal_r <= 1'b0;
   end

   wire logic fault = uv_sync_r[1] | thermal_r;           // [RULE_18]
   wire logic enable = en_sync_r[1] & ctrl_r[`CTRL_ENABLE_BIT]; // [RULE_01]

   // ---------------------------------------------
   // phase machine and keep counter
   // ---------------------------------------------
   logic [31:0] keep_cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r <= ST_OFF;
         keep_cnt_r <= 32'h0000_0000;
      end else if (fault || !enable) begin                // [RULE_22] [RULE_05]
         phase_r <= ST_OFF;
         keep_cnt_r <= 32'h0000_0000;
      end else begin
         case (phase_r)                                   // [RULE_02]
            ST_OFF: begin
               phase_r <= ST_PEAK;
               keep_cnt_r <= keep_r;                      // [RULE_23]
            end
            ST_PEAK: begin
               if (keep_cnt_r <= 32'h0000_0001)           // [RULE_03]
                  phase_r <= ST_HOLD;
               else
                  keep_cnt_r <= keep_cnt_r - 32'h0000_0001;
            end
            ST_HOLD: phase_r <= ST_HOLD;                  // [RULE_04]
            default: phase_r <= ST_OFF;
         endcase
      end
   end

   assign vref = (phase_r == ST_HOLD) ? hold_ref : peak_ref;

   // ---------------------------------------------
   // pwm clock and gate
   // ---------------------------------------------
   logic [19:0] pwm_cnt_r;
   logic [19:0] on_cnt_r;
   wire logic running = (phase_r != ST_OFF) && enable && !fault;
   // tick at start so switching begins at once after enable
   wire logic tick = running && (pwm_cnt_r == 20'h00000); // [RULE_21]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pwm_cnt_r <= 20'h00000;
      else if (!running)
         pwm_cnt_r <= 20'h00000;
      else if (pwm_cnt_r >= per_eff - 20'h00001)
         pwm_cnt_r <= 20'h00000;
      else
         pwm_cnt_r <= pwm_cnt_r + 20'h00001;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_r <= 1'b0;
         on_cnt_r <= 20'h00000;
      end else if (!running) begin                        // [RULE_05]
         gate_r <= 1'b0;
         on_cnt_r <= 20'h00000;
      end else if (tick) begin                            // [RULE_07]
         gate_r <= 1'b1;
         on_cnt_r <= dmin_of(per_eff);                    // [RULE_20]
      end else if (on_cnt_r > 20'h00001) begin            // [RULE_08]
         on_cnt_r <= on_cnt_r - 20'h00001;
      end else begin
         on_cnt_r <= 20'h00000;
         if (sense_s2_r > vref)                           // [RULE_06]
            gate_r <= 1'b0;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         switch_out <= '{gate_drive: 1'b0, status_pull_oe_n: 1'b1};
      else begin
         switch_out.gate_drive <= gate_r & running;
         switch_out.status_pull_oe_n <= fault;            // [RULE_17]
      end
   end
endmodule : solenoid_peak_hold_pwm

//--- logic/solenoid_pkg.sv
// types for the solenoid peak and hold controller
package solenoid_pkg;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_PEAK = 2'b01,
      ST_HOLD = 2'b10
   } phase_t;

   typedef struct packed {
      logic gate_drive;
      logic status_pull_oe_n;
   } switch_out_t;

   typedef struct packed {
      logic supply_low_lockout;
      logic overtemp;
      logic undertemp;
   } protect_in_t;
endpackage : solenoid_pkg

//--- test/solenoid_chk.sv
// assertions on the solenoid controller ports
`timescale 1ns/10ps
module solenoid_chk
   (input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic enable_pin,
    input wire logic [9:0] sense_mv,
    input wire solenoid_pkg::protect_in_t protect_in,
    input wire solenoid_pkg::switch_out_t switch_out);
   import solenoid_pkg::*;
   logic gate;
   logic flt;
   logic [12:0] on_r;
   logic [12:0] low_r;
   logic [4:0] quiet_r;
   assign gate = switch_out.gate_drive;
   assign flt = protect_in.supply_low_lockout | protect_in.overtemp;
   // ----
   // on time and idle gap counters
   // ----
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_r <= 13'h0;
         low_r <= 13'h0;
         quiet_r <= 5'h0;
      end else begin
         // cycles since the last raw fault, saturating
         quiet_r <= flt ? 5'h0 : ((quiet_r == 5'h1F) ? 5'h1F : quiet_r + 5'h1);
         on_r <= gate ? on_r + 13'h1 : 13'h0;
         low_r <= (gate | !enable_pin | flt) ? 13'h0 : low_r + 13'h1;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp set");
   chk_reset_idle: assert property (disable iff (1'b0)
      !hresetn |-> !gate && switch_out.status_pull_oe_n)
      else $error("outputs active in reset");
   chk_fault_gate: assert property (flt [*6] |-> !gate)
      else $error("gate on under fault");
   chk_fault_flag: assert property (
      protect_in.supply_low_lockout [*6] |-> switch_out.status_pull_oe_n)
      else $error("status not released");
   chk_enable_off: assert property (!enable_pin [*6] |-> !gate)
      else $error("gate on while disabled");
   chk_min_on: assert property ($fell(gate) && enable_pin && !flt
      && $past(enable_pin, 8) && quiet_r == 5'h1F |-> on_r >= 13'h177)
      else $error("on time too short");
   chk_sense_cut: assert property ($rose(sense_mv > 10'h384) && gate
      && on_r >= 13'h1E0 |-> ##[1:5] !gate)
      else $error("gate not cut by sense");
   chk_start_gap: assert property (low_r < 13'h1876)
      else $error("no on cycle in time");
   cover property ($rose(gate));
   cover property ($rose(switch_out.status_pull_oe_n));
   cover property ($fell(enable_pin));
endmodule : solenoid_chk

//--- test/solenoid_load.sv
// behavioural switch, solenoid and sense resistor
`timescale 1ns/10ps
module solenoid_load
   (input wire logic hclk,
    input wire logic hresetn,
    input wire logic gate_drive,
    input wire logic shorted,
    output logic [9:0] sense_mv);
   logic [1:0] div_r;
   logic tick;
   assign tick = div_r == 2'h0;
   // ----
   // current ramps while on, decays while off
   // ----
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 2'h0;
         sense_mv <= 10'h0;
      end else begin
         div_r <= div_r + 2'h1;
         if (shorted) begin
            sense_mv <= 10'h3E8;
         end else if (tick && gate_drive && sense_mv < 10'h3E8) begin
            sense_mv <= sense_mv + 10'h1;
         end else if (tick && !gate_drive && sense_mv != 10'h0) begin
            sense_mv <= sense_mv - 10'h1;
         end
      end
   end
endmodule : solenoid_load

//--- test/solenoid_peak_hold_pwm_tb_top.sv
// testbench for the solenoid peak and hold controller
`timescale 1ns/10ps
`include "solenoid_map.svh"
module solenoid_peak_hold_pwm_tb_top;
   import solenoid_pkg::*;
   localparam int MIN_ON = (`PWM_DEF_CYC * `DMIN_PERMILLE + 999) / 1000;
   logic hclk = 1'b0;
   logic hresetn = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic en = 1'b0;
   logic shorted = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   logic [9:0] sense_mv;
   protect_in_t prot = '0;
   switch_out_t sw;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   int on;
   int per;
   always #4 hclk = ~hclk;
   solenoid_peak_hold_pwm #(.HOLD_SETTABLE(1'b1), .KEEP_CYCLES(32'h7530))
      i_solenoid_peak_hold_pwm (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .enable_pin(en),
      .sense_mv(sense_mv), .protect_in(prot), .switch_out(sw));
   solenoid_load i_solenoid_load (.hclk(hclk), .hresetn(hresetn),
      .gate_drive(sw.gate_drive), .shorted(shorted), .sense_mv(sense_mv));
   task conclude;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 95000) begin
         err_total++;
         conclude;
      end
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task cmp_rng(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : cmp_rng
   task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      cmp(rd & m, e);
   endtask : rdc
   task pulse;
      while (sw.gate_drive !== 1'b0) @(posedge hclk);
      while (sw.gate_drive !== 1'b1) @(posedge hclk);
      on = 0;
      while (sw.gate_drive === 1'b1) begin
         @(posedge hclk);
         on++;
      end
      per = on;
      while (sw.gate_drive !== 1'b1) begin
         @(posedge hclk);
         per++;
      end
   endtask : pulse
   task t_regs;
      rdc(`CTRL_OFS, '1, `CTRL_RESET);
      rdc(`KEEP_OFS, '1, 32'h7530);
      xfer(`PEAK_OFS, 1'b1, 32'h64);
      rdc(`PEAK_OFS, 32'h3FF, `PEAK_DEF_MV);
      xfer(`HOLD_OFS, 1'b1, 32'hA);
      rdc(`HOLD_OFS, 32'h3FF, `HOLD_DEF_MV);
      xfer(`PERIOD_OFS, 1'b1, 32'h2328);
      rdc(`PERIOD_OFS, 32'hFFFF, `PWM_DEF_CYC);
      xfer(32'h40, 1'b1, 32'h5);
      rdc(32'h40, '1, 32'h0);
   endtask : t_regs
   task t_peak_hold;
      xfer(`CTRL_OFS, 1'b1, 32'h1);
      en <= 1'b1;
      shorted <= 1'b1;
      pulse;
      cmp_rng(on, MIN_ON, MIN_ON + 4);
      shorted <= 1'b0;
      pulse;
      cmp_rng(on, 4 * `PEAK_DEF_MV, 4 * `PEAK_DEF_MV + 12);
      cmp_rng(per, `PWM_DEF_CYC - 1, `PWM_DEF_CYC + 1);
      rdc(`STAT_OFS, 32'h7, 32'h5);
      repeat (13000) @(posedge hclk);
      rdc(`STAT_OFS, 32'h7, 32'h6);
      pulse;
      cmp_rng(on, MIN_ON, MIN_ON + 4);
      cmp(32'(sw.status_pull_oe_n), 32'h0);
      en <= 1'b0;
      repeat (8) @(posedge hclk);
      cmp(32'(sw.gate_drive), 32'h0);
      rdc(`STAT_OFS, 32'h7, 32'h0);
   endtask : t_peak_hold
   task t_ext;
      xfer(`CTRL_OFS, 1'b1, 32'hF);
      xfer(`KEEP_OFS, 1'b1, 32'h4E20);
      xfer(`PEAK_OFS, 1'b1, `PEAK_MAX_MV);
      xfer(`HOLD_OFS, 1'b1, `HOLD_MAX_MV);
      xfer(`PERIOD_OFS, 1'b1, `PWM_MIN_CYC);
      en <= 1'b1;
      pulse;
      cmp_rng(on, 4 * `PEAK_MAX_MV, 4 * `PEAK_MAX_MV + 12);
      pulse;
      cmp_rng(per, `PWM_MIN_CYC - 1, `PWM_MIN_CYC + 1);
      repeat (13000) @(posedge hclk);
      pulse;
      cmp_rng(on, 4 * `HOLD_MAX_MV, 4 * `HOLD_MAX_MV + 12);
   endtask : t_ext
   task t_fault;
      prot.supply_low_lockout <= 1'b1;
      repeat (8) @(posedge hclk);
      cmp(32'(sw.gate_drive), 32'h0);
      cmp(32'(sw.status_pull_oe_n), 32'h1);
      rdc(`STAT_OFS, 32'h18, 32'h8);
      prot.supply_low_lockout <= 1'b0;
      repeat (8) @(posedge hclk);
      rdc(`STAT_OFS, 32'h3, 32'h1);
      prot.overtemp <= 1'b1;
      repeat (4) @(posedge hclk);
      prot.overtemp <= 1'b0;
      repeat (20) @(posedge hclk);
      rdc(`STAT_OFS, 32'h13, 32'h10);
      prot.undertemp <= 1'b1;
      repeat (4) @(posedge hclk);
      prot.undertemp <= 1'b0;
      repeat (8) @(posedge hclk);
      rdc(`STAT_OFS, 32'h13, 32'h1);
      cmp(32'(sw.status_pull_oe_n), 32'h0);
   endtask : t_fault
   initial begin
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_peak_hold;
      t_ext;
      t_fault;
      conclude;
   end
endmodule : solenoid_peak_hold_pwm_tb_top
bind solenoid_peak_hold_pwm solenoid_chk i_solenoid_chk (.hclk(hclk),
   .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .enable_pin(enable_pin), .sense_mv(sense_mv), .protect_in(protect_in),
   .switch_out(switch_out));
